// *** umic_modem_irq.sv ***
/*
 Modem control, modem status and prioritised interrupt identification for
 one serial channel, with an APB slave for its registers.
 Assumes the serial datapath supplies interrupt source levels and event
 pulses synchronous to core_clk, and that modem lines are synchronous.
*/
// The register offsets and register access over APB were left to the implementer.
// Notes on behaviour
// - Control bit0 drives terminal-ready; loopback feeds status5.
// - Control bit1 drives request-to-send unless auto flow.
// - Control bit2 enables fifo-ready status; loopback status6.
// - Control bit3 enables interrupt drive; loopback status7.
// - Control bit4 loops control and serial data internally.
// - Control bit5 enables resume on any character.
// - Control bit6 opens threshold and trigger registers.
// - Control bit7 prescales; resets to inverted select pin.
// - Control bits 7..5 writable only when enhanced.
// - Status bits 0,1,3 latch changes; cleared on read.
// - Status bit2 latches ring rising only; read clears.
// - Status bits 7..4 show lines or loopback sources.
// - Enabled pending interrupt activates interrupt output.
// - Enable bits 0..3 gate the four classic sources.
// - Enable bits 4..7: sleep, xoff, rts, cts.
// - Enable bits 7..4 writable only when enhanced.
// - Re-enabling transmit interrupt raises fresh one if low.
// - Identification read-only; bit0 low while pending.
// - Id bit4 xoff/special, bit5 cts/rts change.
// - Id bits 7 and 6 mirror fifo enable.
// - Priorities one to three: line, timeout/receive, transmit.
// - Priorities four to six: modem, xoff, flow.
// - Enhanced bit is write enable for protected fields.
module umic_modem_irq
    import umic_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Modem lines, active low
    input  wire logic        cts_n,
    input  wire logic        dsr_n,
    input  wire logic        ri_n,
    input  wire logic        cd_n,
    output logic             dtr_n,
    output logic             rts_n,
    // Straps and hardware flow control
    input  wire logic        clock_prescale_select_pin,
    input  wire logic        auto_rts_en,
    input  wire logic        auto_rts_n,
    // Interrupt sources from the datapath
    input  wire logic        line_err,
    input  wire logic        rx_timeout,
    input  wire logic        rx_ready,
    input  wire logic        tx_below_thr,
    input  wire logic        xoff_det,
    input  wire logic        cts_inactive,
    input  wire logic        rts_inactive,
    // Interrupt pin as output and enable
    output logic             irq,
    output logic             irq_oe,
    // Controls to the rest of the channel
    output logic             loopback_en,
    output logic             prescale_div4,
    output logic             xon_any_en,
    output logic             flow_reg_access,
    output logic             fifo_ready_status_en,
    output logic             sleep_en
);

    umic_state_s s_q;
    umic_state_s s_d;

    logic        loop;
    logic [3:0]  lines;
    logic [7:0]  msr_view;
    logic [5:0]  id;
    logic        any_pend;
    logic        acc;
    logic        wr_done;
    logic        rd_done;
    logic [7:0]  wbyte;
    logic [7:0]  rd_val;
    logic        hit;

    // Line view: {cd, ri, dsr, cts}, active high
    always_comb begin
        loop  = s_q.modem_control[UMIC_MC_LOOP];
        if (loop) begin
            lines = {s_q.modem_control[UMIC_MC_IRQ_EN], s_q.modem_control[UMIC_MC_FRDY],
                     s_q.modem_control[UMIC_MC_DTR], s_q.modem_control[UMIC_MC_RTS]};
        end else begin
            lines = {~cd_n, ~ri_n, ~dsr_n, ~cts_n};
        end
        msr_view = {lines, s_q.delta};
    end

    // Priority encoder of enabled sources
    always_comb begin
        if (s_q.interrupt_enable[UMIC_IE_LSR] && line_err) begin
            id = UMIC_ID_LSE;
        end else if (s_q.interrupt_enable[UMIC_IE_RXH] && rx_timeout) begin
            id = UMIC_ID_RTO;
        end else if (s_q.interrupt_enable[UMIC_IE_RXH] && rx_ready) begin
            id = UMIC_ID_RXH;
        end else if (s_q.interrupt_enable[UMIC_IE_TXH] && s_q.thr_pend) begin
            id = UMIC_ID_TXH;
        end else if (s_q.interrupt_enable[UMIC_IE_MODEM] && (|s_q.delta)) begin
            id = UMIC_ID_MODEM;
        end else if (s_q.interrupt_enable[UMIC_IE_XOFF] && s_q.xoff_pend) begin
            id = UMIC_ID_XOFF;
        end else if ((s_q.interrupt_enable[UMIC_IE_CTS] && s_q.cts_pend) ||
                     (s_q.interrupt_enable[UMIC_IE_RTS] && s_q.rts_pend)) begin
            id = UMIC_ID_FLOW;
        end else begin
            id = UMIC_ID_NONE;
        end
        any_pend = (id != UMIC_ID_NONE);
    end

    // Bus phase decode and read mux
    always_comb begin
        acc     = psel && penable;
        wr_done = acc && s_q.pready && pwrite;
        rd_done = acc && s_q.pready && !pwrite;
        wbyte   = pwdata[7:0];
        hit     = 1'b1;
        rd_val  = 8'h00;
        if (paddr == UMIC_OFF_MODEM_CONTROL) begin
            rd_val = s_q.modem_control;
        end else if (paddr == UMIC_OFF_MODEM_STATUS) begin
            rd_val = msr_view;
        end else if (paddr == UMIC_OFF_INT_ENABLE) begin
            rd_val = s_q.interrupt_enable;
        end else if (paddr == UMIC_OFF_INT_IDENT) begin
            rd_val = {{2{s_q.fifo_control[UMIC_FC_EN]}}, id};
        end else if (paddr == UMIC_OFF_ENHANCED) begin
            rd_val = s_q.enhanced_feature_reg;
        end else if (paddr == UMIC_OFF_FIFO_CONTROL) begin
            rd_val = s_q.fifo_control;
        end else begin
            hit    = 1'b0;
        end
    end

    // Next state
    always_comb begin
        s_d = s_q;

        // One wait state: answer in the second access cycle
        s_d.pready = acc && !s_q.pready;
        if (acc && !s_q.pready) begin
            s_d.prdata  = {24'h000000, rd_val};
            s_d.pslverr = !hit;
        end else begin
            s_d.pslverr = 1'b0;
        end

        // Register writes; protected fields need the enhanced enable
        if (wr_done) begin
            if (paddr == UMIC_OFF_MODEM_CONTROL) begin
                if (s_q.enhanced_feature_reg[UMIC_EF_ENH]) begin
                    s_d.modem_control = wbyte;
                end else begin
                    s_d.modem_control = (s_q.modem_control & UMIC_MCR_PROT) | (wbyte & ~UMIC_MCR_PROT);
                end
            end else if (paddr == UMIC_OFF_INT_ENABLE) begin
                if (s_q.enhanced_feature_reg[UMIC_EF_ENH]) begin
                    s_d.interrupt_enable = wbyte;
                end else begin
                    s_d.interrupt_enable = (s_q.interrupt_enable & UMIC_IER_PROT) | (wbyte & ~UMIC_IER_PROT);
                end
            end else if (paddr == UMIC_OFF_ENHANCED) begin
                s_d.enhanced_feature_reg = wbyte;
            end else if (paddr == UMIC_OFF_FIFO_CONTROL) begin
                if (s_q.enhanced_feature_reg[UMIC_EF_ENH]) begin
                    s_d.fifo_control = wbyte;
                end else begin
                    s_d.fifo_control = (s_q.fifo_control & UMIC_FCR_PROT) | (wbyte & ~UMIC_FCR_PROT);
                end
            end
        end

        // Read side effects use the value that was actually returned
        if (rd_done && paddr == UMIC_OFF_MODEM_STATUS) begin
            s_d.delta = s_q.delta & ~s_q.prdata[3:0];
        end
        if (rd_done && paddr == UMIC_OFF_INT_IDENT) begin
            if (s_q.prdata[5:0] == UMIC_ID_TXH) begin
                s_d.thr_pend = 1'b0;
            end
            if (s_q.prdata[5:0] == UMIC_ID_XOFF) begin
                s_d.xoff_pend = 1'b0;
            end
            if (s_q.prdata[5:0] == UMIC_ID_FLOW) begin
                s_d.cts_pend = 1'b0;
                s_d.rts_pend = 1'b0;
            end
        end

        // Change detection; a new change beats a read clear
        s_d.prime = 1'b1;
        s_d.prev  = lines;
        if (s_q.prime) begin
            s_d.delta[0] = s_d.delta[0] | (lines[0] ^ s_q.prev[0]);
            s_d.delta[1] = s_d.delta[1] | (lines[1] ^ s_q.prev[1]);
            s_d.delta[2] = s_d.delta[2] | (lines[2] & ~s_q.prev[2]);
            s_d.delta[3] = s_d.delta[3] | (lines[3] ^ s_q.prev[3]);
        end

        // Transmit-holding source: on threshold crossing or re-enable
        s_d.tx_prev = tx_below_thr;
        if (!tx_below_thr) begin
            s_d.thr_pend = 1'b0;
        end
        if (tx_below_thr && !s_q.tx_prev) begin
            s_d.thr_pend = 1'b1;
        end
        if (wr_done && paddr == UMIC_OFF_INT_ENABLE && wbyte[UMIC_IE_TXH]
            && !s_q.interrupt_enable[UMIC_IE_TXH] && tx_below_thr) begin
            s_d.thr_pend = 1'b1;
        end

        // Event sources, set wins over read clear
        if (xoff_det) begin
            s_d.xoff_pend = 1'b1;
        end
        if (cts_inactive) begin
            s_d.cts_pend = 1'b1;
        end
        if (rts_inactive) begin
            s_d.rts_pend = 1'b1;
        end

        // Registered pin drive
        if (loop) begin
            s_d.dtr_n = 1'b1;
            s_d.rts_n = 1'b1;
        end else begin
            s_d.dtr_n = ~s_q.modem_control[UMIC_MC_DTR];
            if (auto_rts_en) begin
                s_d.rts_n = auto_rts_n;
            end else begin
                s_d.rts_n = ~s_q.modem_control[UMIC_MC_RTS];
            end
        end
        s_d.irq    = any_pend;
        s_d.irq_oe = s_q.modem_control[UMIC_MC_IRQ_EN] && !loop;
    end

    // State register; prescale select strapped from the pin during reset
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q          <= '0;
            s_q.modem_control      <= {~clock_prescale_select_pin, 7'h00};
            s_q.interrupt_enable      <= UMIC_RST_REG;
            s_q.enhanced_feature_reg      <= UMIC_RST_REG;
            s_q.fifo_control      <= UMIC_RST_REG;
            s_q.dtr_n    <= 1'b1;
            s_q.rts_n    <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flops
    assign prdata               = s_q.prdata;
    assign pready               = s_q.pready;
    assign pslverr              = s_q.pslverr;
    assign dtr_n                = s_q.dtr_n;
    assign rts_n                = s_q.rts_n;
    assign irq                  = s_q.irq;
    assign irq_oe               = s_q.irq_oe;
    assign loopback_en          = s_q.modem_control[UMIC_MC_LOOP];
    assign prescale_div4        = s_q.modem_control[UMIC_MC_DIV4];
    assign xon_any_en           = s_q.modem_control[UMIC_MC_XANY];
    assign flow_reg_access      = s_q.modem_control[UMIC_MC_ACCESS];
    assign fifo_ready_status_en = s_q.modem_control[UMIC_MC_FRDY];
    assign sleep_en             = s_q.interrupt_enable[UMIC_IE_SLEEP];

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence mcr_write_s;
        wr_done && paddr == UMIC_OFF_MODEM_CONTROL;
    endsequence

    chk_dtr_drive: assert property (
        mcr_write_s and (wbyte[UMIC_MC_DTR] && !wbyte[UMIC_MC_LOOP])
        |=> !wr_done ##1 !dtr_n)
        else $error("terminal-ready not driven low after control write");

    chk_mcr_protect: assert property (
        mcr_write_s and !s_q.enhanced_feature_reg[UMIC_EF_ENH]
        |=> s_q.modem_control[7:5] == $past(s_q.modem_control[7:5]))
        else $error("protected control bits changed without enhanced enable");

    chk_ier_protect: assert property (
        wr_done && paddr == UMIC_OFF_INT_ENABLE && !s_q.enhanced_feature_reg[UMIC_EF_ENH]
        |=> s_q.interrupt_enable[7:4] == $past(s_q.interrupt_enable[7:4]))
        else $error("protected enable bits changed without enhanced enable");

    chk_delta_clear: assert property (
        rd_done && paddr == UMIC_OFF_MODEM_STATUS && lines == s_q.prev && s_q.prime
        |=> s_q.delta == ($past(s_q.delta) & ~$past(s_q.prdata[3:0])))
        else $error("status change bits not cleared by read");

    chk_ring_rise: assert property (
        s_q.prime && lines[2] && !s_q.prev[2] |=> s_q.delta[2])
        else $error("ring rising edge not latched");

    chk_irq_follow: assert property (
        any_pend ##1 any_pend |-> irq)
        else $error("interrupt output not active while a source pends");

    chk_lse_first: assert property (
        s_q.interrupt_enable[UMIC_IE_LSR] && line_err |-> id == UMIC_ID_LSE)
        else $error("line status error not reported first");

    chk_thr_reenable: assert property (
        wr_done && paddr == UMIC_OFF_INT_ENABLE && wbyte[UMIC_IE_TXH]
        && !s_q.interrupt_enable[UMIC_IE_TXH] && tx_below_thr
        |=> s_q.thr_pend)
        else $error("re-enable of transmit interrupt did not raise it");

    chk_irq_drive: assert property (
        s_q.modem_control[UMIC_MC_IRQ_EN] && !s_q.modem_control[UMIC_MC_LOOP] |=> irq_oe)
        else $error("interrupt pin not driven while enabled");

    chk_prescale: assert property (
        $fell(rst) |-> prescale_div4 == !$past(clock_prescale_select_pin))
        else $error("prescale select not taken from inverted pin");

    chk_loop_status: assert property (
        loop |-> msr_view[7:4] == {s_q.modem_control[3], s_q.modem_control[2], s_q.modem_control[0], s_q.modem_control[1]})
        else $error("loopback status lines do not follow control bits");

    // Identification read, pin drive and fifo control protection
    sequence iir_read_s;
        rd_done && paddr == UMIC_OFF_INT_IDENT;
    endsequence

    chk_ident_mirror: assert property (
        iir_read_s |-> prdata[7:6] == {2{s_q.fifo_control[UMIC_FC_EN]}})
        else $error("identification bits 7 and 6 do not mirror fifo enable");

    chk_pend_flag: assert property (
        iir_read_s ##0 $past(any_pend)
        |-> !prdata[0])
        else $error("identification bit 0 high while a source pends");

    chk_fcr_protect: assert property (
        wr_done && paddr == UMIC_OFF_FIFO_CONTROL && !s_q.enhanced_feature_reg[UMIC_EF_ENH]
        |=> (s_q.fifo_control & UMIC_FCR_PROT) == ($past(s_q.fifo_control) & UMIC_FCR_PROT))
        else $error("protected fifo control bits changed without enhanced enable");

    chk_rts_auto: assert property (
        auto_rts_en && !loop
        |=> rts_n == $past(auto_rts_n))
        else $error("request-to-send does not follow hardware flow control");

    chk_loop_pins: assert property (
        loop |=> dtr_n && rts_n && !irq_oe)
        else $error("modem outputs not held inactive in loopback");

endmodule : umic_modem_irq

// *** umic_modem_irq_bench.sv ***
/*
 Self-checking bench for the modem control and interrupt block.
 Assumes the block's APB answer timing and a modem model on the lines.
*/
module umic_modem_irq_bench import umic_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // Short names for the register addresses; source patterns and identification values
    localparam logic [7:0] MC = UMIC_OFF_MODEM_CONTROL;
    localparam logic [7:0] MS = UMIC_OFF_MODEM_STATUS;
    localparam logic [7:0] IE = UMIC_OFF_INT_ENABLE;
    localparam logic [7:0] ID = UMIC_OFF_INT_IDENT;
    localparam logic [3:0] SRCS [4] = '{4'hF, 4'h7, 4'h3, 4'h1};
    localparam logic [7:0] IDS [4] = '{8'hC6, 8'hCC, 8'hC4, 8'hC2};

    // Stimulus and observed signals
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, dtr_n, rts_n, cts_n, dsr_n, ri_n, cd_n;
    logic        clock_prescale_select_pin = 1'b0, auto_rts_en = 1'b0, auto_rts_n = 1'b1;
    logic        line_err = 1'b0, rx_timeout = 1'b0, rx_ready = 1'b0, tx_below_thr = 1'b0;
    logic        xoff_det = 1'b0, cts_inactive = 1'b0, rts_inactive = 1'b0;
    logic        irq, irq_oe, loopback_en, prescale_div4, xon_any_en;
    logic        flow_reg_access, fifo_ready_status_en, sleep_en;
    logic [3:0]  line_cmd = 4'h0;
    int          n_fail = 0, n_compared = 0, cyc = 0;

    // Clock, 8 ns period
    always #4 core_clk = ~core_clk;

    umic_modem_irq i_dut (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .cts_n, .dsr_n, .ri_n, .cd_n, .dtr_n, .rts_n,
        .clock_prescale_select_pin, .auto_rts_en, .auto_rts_n, .line_err, .rx_timeout,
        .rx_ready, .tx_below_thr, .xoff_det, .cts_inactive, .rts_inactive, .irq, .irq_oe,
        .loopback_en, .prescale_div4, .xon_any_en, .flow_reg_access,
        .fifo_ready_status_en, .sleep_en);

    umic_modem_model i_modem (.core_clk, .rst, .line_cmd, .cts_n, .dsr_n, .ri_n, .cd_n);

    // Verdict and end of run
    task automatic stop_test();
        $display("Compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test

    // Cut a hang short
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            stop_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, rd);
    endtask : rc

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick

    // Level sources {line_err, rx_timeout, rx_ready, tx_below_thr}
    task automatic src(input logic [3:0] s);
        @(posedge core_clk);
        {line_err, rx_timeout, rx_ready, tx_below_thr} <= s;
        tick(3);
    endtask : src

    // One-cycle events {xoff_det, cts_inactive, rts_inactive}
    task automatic pulse(input logic [2:0] v);
        @(posedge core_clk);
        {xoff_det, cts_inactive, rts_inactive} <= v;
        @(posedge core_clk);
        {xoff_det, cts_inactive, rts_inactive} <= 3'b000;
        tick(3);
    endtask : pulse

    // Main sequence
    initial begin
        tick(16);
        rst <= 1'b0;
        tick(2);
        rc("mcr reset", MC, 32'h80);
        rc("ier reset", IE, 32'h00);
        rc("iir idle", ID, 32'h01);
        chk("dtr idle", 1'b1, dtr_n);
        chk("irq_oe idle", 1'b0, irq_oe);
        wr(MC, 32'h6F);
        wr(IE, 32'hFF);
        rc("mcr locked", MC, 32'h8F);
        rc("ier locked", IE, 32'h0F);
        wr(UMIC_OFF_FIFO_CONTROL, 32'h30);
        rc("fcr locked", UMIC_OFF_FIFO_CONTROL, 32'h00);
        chk("dtr on", 1'b0, dtr_n);
        chk("rts on", 1'b0, rts_n);
        chk("irq_oe on", 1'b1, irq_oe);
        chk("frdy on", 1'b1, fifo_ready_status_en);
        chk("xany locked", 1'b0, xon_any_en);
        @(posedge core_clk);
        auto_rts_en <= 1'b1;
        tick(3);
        chk("auto rts", 1'b1, rts_n);
        @(posedge core_clk);
        auto_rts_en <= 1'b0;
        wr(UMIC_OFF_ENHANCED, 32'h10);
        wr(MC, 32'h6F);
        wr(IE, 32'hFF);
        wr(UMIC_OFF_FIFO_CONTROL, 32'h01);
        rc("mcr open", MC, 32'h6F);
        chk("div1", 1'b0, prescale_div4);
        chk("xany on", 1'b1, xon_any_en);
        chk("regs open", 1'b1, flow_reg_access);
        chk("sleep on", 1'b1, sleep_en);
        rc("msr quiet", MS, 32'h00);
        // Modem lines change: cts, dsr and cd asserted
        @(posedge core_clk);
        line_cmd <= 4'hB;
        tick(3);
        rc("iir modem", ID, 32'hC8);
        chk("irq modem", 1'b1, irq);
        rc("msr change", MS, 32'hBB);
        rc("msr cleared", MS, 32'hB0);
        @(posedge core_clk);
        line_cmd <= 4'h0;
        tick(3);
        rc("msr release", MS, 32'h0B);
        // Sources dropped one by one in priority order
        for (int i = 0; i < 4; i++) begin
            src(SRCS[i]);
            rc("iir prio", ID, IDS[i]);
            chk("irq held", 1'b1, irq);
        end
        rc("iir tx read", ID, 32'hC1);
        chk("irq off", 1'b0, irq);
        wr(IE, 32'hFD);
        wr(IE, 32'hFF);
        rc("iir tx again", ID, 32'hC2);
        rc("iir tx read2", ID, 32'hC1);
        pulse(3'b100);
        rc("iir xoff", ID, 32'hD0);
        pulse(3'b010);
        rc("iir cts", ID, 32'hE0);
        pulse(3'b001);
        rc("iir rts", ID, 32'hE0);
        rc("iir none", ID, 32'hC1);
        // Masking of a pending line error
        src(4'h8);
        wr(IE, 32'h00);
        rc("iir masked", ID, 32'hC1);
        chk("irq masked", 1'b0, irq);
        wr(IE, 32'h04);
        rc("iir unmasked", ID, 32'hC6);
        chk("irq unmasked", 1'b1, irq);
        src(4'h0);
        wr(ID, 32'hFF);
        rc("iir readonly", ID, 32'hC1);
        // Internal loopback
        wr(MC, 32'h10);
        apb(1'b0, MS, 32'h0);
        rc("msr loop0", MS, 32'h00);
        chk("loop on", 1'b1, loopback_en);
        wr(MC, 32'h1F);
        rc("msr loop1", MS, 32'hFF);
        chk("dtr loop", 1'b1, dtr_n);
        chk("rts loop", 1'b1, rts_n);
        chk("irq_oe loop", 1'b0, irq_oe);
        wr(MC, 32'h10);
        rc("msr loop2", MS, 32'h0B);
        // Unmapped address answers with an error and zero data
        apb(1'b0, 8'h18, 32'h0);
        chk("slverr", 1'b1, err);
        chk("unmapped data", 32'h0, rd);
        // Second reset with the prescale strap high
        @(posedge core_clk);
        clock_prescale_select_pin <= 1'b1;
        rst <= 1'b1;
        tick(16);
        rst <= 1'b0;
        tick(2);
        rc("mcr strap", MC, 32'h00);
        chk("dtr reset", 1'b1, dtr_n);
        stop_test();
    end
endmodule : umic_modem_irq_bench

// *** umic_modem_model.sv ***
/*
 Modem or data set model that drives the active-low handshake lines.
 Assumes the bench commands the asserted lines synchronously to core_clk.
*/
module umic_modem_model (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // Lines to assert, {cd, ri, dsr, cts}
    input  wire logic [3:0] line_cmd,
    // Handshake lines, active low
    output logic            cts_n,
    output logic            dsr_n,
    output logic            ri_n,
    output logic            cd_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // Lines rest inactive in reset, then follow the commanded levels
    always_ff @(posedge core_clk) begin
        if (rst) begin
            {cd_n, ri_n, dsr_n, cts_n} <= 4'hF;
        end else begin
            {cd_n, ri_n, dsr_n, cts_n} <= ~line_cmd;
        end
    end
endmodule : umic_modem_model

// *** umic_pkg.sv ***
/*
 Constants, field positions and the state record for the modem-control,
 modem-status and prioritised interrupt block of one serial channel.
 Assumes a 32-bit APB register bus with one aligned word per register.
*/
package umic_pkg;

    // Register byte addresses
    localparam logic [7:0] UMIC_OFF_MODEM_CONTROL   = 8'h00;
    localparam logic [7:0] UMIC_OFF_MODEM_STATUS    = 8'h04;
    localparam logic [7:0] UMIC_OFF_INT_ENABLE      = 8'h08;
    localparam logic [7:0] UMIC_OFF_INT_IDENT       = 8'h0C;
    localparam logic [7:0] UMIC_OFF_ENHANCED        = 8'h10;
    localparam logic [7:0] UMIC_OFF_FIFO_CONTROL    = 8'h14;

    // Modem control fields
    localparam int UMIC_MC_DTR    = 0;
    localparam int UMIC_MC_RTS    = 1;
    localparam int UMIC_MC_FRDY   = 2;
    localparam int UMIC_MC_IRQ_EN = 3;
    localparam int UMIC_MC_LOOP   = 4;
    localparam int UMIC_MC_XANY   = 5;
    localparam int UMIC_MC_ACCESS = 6;
    localparam int UMIC_MC_DIV4   = 7;

    // Interrupt enable fields
    localparam int UMIC_IE_RXH   = 0;
    localparam int UMIC_IE_TXH   = 1;
    localparam int UMIC_IE_LSR   = 2;
    localparam int UMIC_IE_MODEM = 3;
    localparam int UMIC_IE_SLEEP = 4;
    localparam int UMIC_IE_XOFF  = 5;
    localparam int UMIC_IE_RTS   = 6;
    localparam int UMIC_IE_CTS   = 7;

    // Enhanced feature and fifo control fields
    localparam int UMIC_EF_ENH = 4;
    localparam int UMIC_FC_EN  = 0;

    // Fields writable only with the enhanced write enable set
    localparam logic [7:0] UMIC_MCR_PROT = 8'hE0;
    localparam logic [7:0] UMIC_IER_PROT = 8'hF0;
    localparam logic [7:0] UMIC_FCR_PROT = 8'h30;

    // Reset values
    localparam logic [7:0] UMIC_RST_REG = 8'h00;

    // Identification codes, bits 5..0
    localparam logic [5:0] UMIC_ID_NONE  = 6'h01;
    localparam logic [5:0] UMIC_ID_LSE   = 6'h06;
    localparam logic [5:0] UMIC_ID_RTO   = 6'h0C;
    localparam logic [5:0] UMIC_ID_RXH   = 6'h04;
    localparam logic [5:0] UMIC_ID_TXH   = 6'h02;
    localparam logic [5:0] UMIC_ID_MODEM = 6'h08;
    localparam logic [5:0] UMIC_ID_XOFF  = 6'h10;
    localparam logic [5:0] UMIC_ID_FLOW  = 6'h20;

    // Whole state of the block
    typedef struct packed {
        logic [7:0]  modem_control;
        logic [7:0]  interrupt_enable;
        logic [7:0]  enhanced_feature_reg;
        logic [7:0]  fifo_control;
        logic [3:0]  delta;
        logic [3:0]  prev;
        logic        prime;
        logic        tx_prev;
        logic        thr_pend;
        logic        xoff_pend;
        logic        cts_pend;
        logic        rts_pend;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        dtr_n;
        logic        rts_n;
        logic        irq;
        logic        irq_oe;
    } umic_state_s;

endpackage : umic_pkg
